/* hdl/cluster_err_pkg.sv */
// Purpose: Shared constants and types for the adapter error status block.
// Assumes: Registers sit on an Avalon-MM slave with 32-bit data, word aligned.
// Notes:   Bit positions follow the bus status word and the link error word.
package cluster_err_pkg;

  // Register byte offsets.
  localparam logic [3:0] OFS_PCI_STATUS   = 4'h0;
  localparam logic [3:0] OFS_LINK_ERROR   = 4'h4;
  localparam logic [3:0] OFS_LINK_CTRL    = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK     = 4'hC;

  // Bus status word bit positions.
  localparam int BIT_DET_PARITY  = 31;
  localparam int BIT_SIG_ERROR   = 30;
  localparam int BIT_RCV_MABORT  = 29;
  localparam int BIT_RCV_TABORT  = 28;
  localparam int BIT_MST_DPERR   = 24;

  // Link error word bit positions.
  localparam int BIT_HUB_TIMEOUT = 30;
  localparam int BIT_HBEAT_A     = 29;
  localparam int BIT_HBEAT_B     = 27;

  // Link control and status bit positions.
  localparam int BIT_TX_SUMMARY  = 0;
  localparam int BIT_HBEAT_EN    = 16;

  // Reset values.
  localparam logic [31:0] RST_STATUS   = 32'h0000_0000;
  localparam logic [31:0] RST_MASK     = 32'h0000_0000;
  localparam logic        RST_HBEAT_EN = 1'b1;

  // Clock and times.
  localparam int CLOCK_HZ          = 40_000_000;
  localparam int HUB_TIMEOUT_US    = 1000;
  localparam int HBEAT_PERIOD_MS   = 750;
  localparam longint HUB_CYCLES_L  = (longint'(HUB_TIMEOUT_US) * CLOCK_HZ) / 1_000_000;
  localparam longint HBEAT_CYCLES_L = (longint'(HBEAT_PERIOD_MS) * CLOCK_HZ) / 1_000;
  localparam int HUB_CYCLES        = int'(HUB_CYCLES_L);
  localparam int HBEAT_CYCLES      = int'(HBEAT_CYCLES_L);

  // Bus-side error events from the PCI engine, one-cycle pulses.
  typedef struct packed {
    logic addrParity;    // Address phase parity error seen.
    logic isMaster;      // Adapter owns the bus this cycle.
    logic writeParity;   // Data parity error on a write while target.
    logic noClaim;       // Own transaction not claimed by any target.
    logic targetAbort;   // Target signalled abort on own transaction.
    logic perrSeen;      // Parity error report seen on own write.
  } pci_evt_type;

  // Avalon-MM request group.
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avm_req_type;

endpackage : cluster_err_pkg

/* hdl/timeout_counter.sv */
// Purpose: Up counter that flags expiry of a wait that is still armed.
// Assumes: Restart and arm are synchronous to clock.
// Notes:   Expiry is a one-cycle pulse; the counter then idles until restart or disarm.
`timescale 1ns/1ps
module timeout_counter #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] LIMIT = '1
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic srst,
  // Control.
  input  wire logic arm,
  input  wire logic restart,
  // Result.
  output logic      expired
);

  logic [WIDTH-1:0] count_ff;
  logic             done_ff;
  wire  logic       atEnd = (count_ff == LIMIT - 1'b1);

  // Count while armed; a restart or disarm reloads so a fresh wait starts clean.
  always_ff @(posedge clock) begin
    if (srst || restart || !arm) begin
      count_ff <= '0;
      done_ff  <= 1'b0;
      expired  <= 1'b0;
    end else begin
      expired <= atEnd && !done_ff;
      if (atEnd) begin
        done_ff <= 1'b1;
      end else begin
        count_ff <= count_ff + 1'b1;
      end
    end
  end

endmodule // timeout_counter

/* hdl/cluster_adapter_error_status.sv */
// Purpose: Error detection and sticky status for the bus and cluster link.
// Assumes: Event inputs come from same-clock logic; link pins are synchronised here.
// Notes:   Status bits are write-one-to-clear; a set in the same cycle wins.
//
// What this block does
// - Address parity as non-master sets bits 31,30.
// - Target write data parity sets 31 only.
// - Unclaimed own transaction sets master abort 29.
// - Target abort on own transaction sets 28.
// - Parity report on own write sets 24.
// - Unanswered link request sets hub timeout 30.
// - No host transmit per period sets 29,27.
// - Any transmit-path error sets summary bit 0.
`timescale 1ns/1ps
module cluster_adapter_error_status
  import cluster_err_pkg::*;
#(
  parameter int HUB_LIMIT   = HUB_CYCLES,
  parameter int HBEAT_LIMIT = HBEAT_CYCLES
) (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        srst,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Bus engine events.
  input  wire pci_evt_type pciEvt,
  // Cluster link pins and host activity.
  input  wire logic        linkRequest,
  input  wire logic        linkGrant,
  input  wire logic        hostTxPulse,
  // Master control: end own transaction after abort.
  output logic             masterTerminate,
  // Interrupt.
  output logic             irq
);

  // Avalon request bundled for decoding.
  avm_req_type req;
  assign req = '{address: address, read: read, write: write,
                 byteenable: byteenable, writedata: writedata};

  // Registers.
  logic [31:0] pciStatus_ff;
  logic [31:0] linkError_ff;
  logic        txSummary_ff;
  logic        hbeatEnable_ff;
  logic [31:0] irqMask_ff;
  logic        ack_ff;

  // Link pin synchronisers; the first stage is read only by the second.
  logic reqSync1_ff, reqSync2_ff;
  logic gntSync1_ff, gntSync2_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      reqSync1_ff <= 1'b0;
      reqSync2_ff <= 1'b0;
      gntSync1_ff <= 1'b0;
      gntSync2_ff <= 1'b0;
    end else begin
      reqSync1_ff <= linkRequest;
      reqSync2_ff <= reqSync1_ff;
      gntSync1_ff <= linkGrant;
      gntSync2_ff <= gntSync1_ff;
    end
  end

  // Byte-lane expansion used for both write-one-to-clear and plain writes.
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Address decode; waitrequest holds for one cycle so every access takes two.
  wire logic        accept   = (req.read || req.write) && !ack_ff;
  wire logic        wrTake   = req.write && ack_ff;
  wire logic [31:0] wrLanes  = laneMask(req.byteenable) & req.writedata;
  wire logic        selPci   = (req.address == OFS_PCI_STATUS);
  wire logic        selLink  = (req.address == OFS_LINK_ERROR);
  wire logic        selCtrl  = (req.address == OFS_LINK_CTRL);
  wire logic        selMask  = (req.address == OFS_IRQ_MASK);
  wire logic [31:0] clrPci   = (wrTake && selPci)  ? wrLanes : 32'h0000_0000;
  wire logic [31:0] clrLink  = (wrTake && selLink) ? wrLanes : 32'h0000_0000;
  wire logic        clrSum   = wrTake && selCtrl && byteenable[0] && writedata[BIT_TX_SUMMARY];

  // Bus-side event decode.
  wire logic evAddrPar  = pciEvt.addrParity && !pciEvt.isMaster;
  wire logic evWritePar = pciEvt.writeParity && !pciEvt.isMaster;
  wire logic evMAbort   = pciEvt.noClaim && pciEvt.isMaster;
  wire logic evTAbort   = pciEvt.targetAbort && pciEvt.isMaster;
  wire logic evMstPerr  = pciEvt.perrSeen && pciEvt.isMaster;

  // Timers for the link side.
  logic hubExpired;
  logic hbeatExpired;
  wire  logic hubWaiting = reqSync2_ff && !gntSync2_ff;

  // Hub wait: armed while request is up and grant not yet seen.
  timeout_counter #(
    .WIDTH (32),
    .LIMIT (32'(HUB_LIMIT))
  ) u_hub_timer (
    .clock   (clock),
    .srst    (srst),
    .arm     (hubWaiting),
    .restart (1'b0),
    .expired (hubExpired)
  );

  // Heartbeat: restarted by every host transmit.
  timeout_counter #(
    .WIDTH (32),
    .LIMIT (32'(HBEAT_LIMIT))
  ) u_hbeat_timer (
    .clock   (clock),
    .srst    (srst),
    .arm     (hbeatEnable_ff),
    .restart (hostTxPulse),
    .expired (hbeatExpired)
  );

  // Set vectors for the sticky words.
  logic [31:0] setPci;
  logic [31:0] setLink;
  always_comb begin
    setPci  = 32'h0000_0000;
    setLink = 32'h0000_0000;
    setPci[BIT_DET_PARITY]  = evAddrPar || evWritePar;
    setPci[BIT_SIG_ERROR]   = evAddrPar;
    setPci[BIT_RCV_MABORT]  = evMAbort;
    setPci[BIT_RCV_TABORT]  = evTAbort;
    setPci[BIT_MST_DPERR]   = evMstPerr;
    setLink[BIT_HUB_TIMEOUT] = hubExpired;
    setLink[BIT_HBEAT_A]     = hbeatExpired;
    setLink[BIT_HBEAT_B]     = hbeatExpired;
  end

  // Transmit-path errors: master-side bus faults and all link faults.
  wire logic txPathErr = evMAbort || evTAbort || evMstPerr || (|setLink);

  // Sticky words: set wins over a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      pciStatus_ff <= RST_STATUS;
      linkError_ff <= RST_STATUS;
      txSummary_ff <= 1'b0;
    end else begin
      pciStatus_ff <= (pciStatus_ff & ~clrPci) | setPci;
      linkError_ff <= (linkError_ff & ~clrLink) | setLink;
      txSummary_ff <= (txSummary_ff && !clrSum) || txPathErr;
    end
  end

  // Control registers written by software.
  always_ff @(posedge clock) begin
    if (srst) begin
      hbeatEnable_ff <= RST_HBEAT_EN;
      irqMask_ff     <= RST_MASK;
    end else if (wrTake) begin
      if (selCtrl && byteenable[2]) begin
        hbeatEnable_ff <= writedata[BIT_HBEAT_EN];
      end
      if (selMask) begin
        irqMask_ff <= (irqMask_ff & ~laneMask(byteenable)) | wrLanes;
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  logic [31:0] ctrlWord;
  logic [31:0] rdMux;
  always_comb begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[BIT_TX_SUMMARY] = txSummary_ff;
    ctrlWord[BIT_HBEAT_EN]   = hbeatEnable_ff;
    rdMux = 32'h0000_0000;
    if (selPci) begin
      rdMux = pciStatus_ff;
    end else if (selLink) begin
      rdMux = linkError_ff;
    end else if (selCtrl) begin
      rdMux = ctrlWord;
    end else if (selMask) begin
      rdMux = irqMask_ff;
    end
  end

  // Interrupt summary over both sticky words and the summary bit.
  wire logic irqNext = |((pciStatus_ff | linkError_ff) & irqMask_ff)
                       || (txSummary_ff && irqMask_ff[BIT_TX_SUMMARY]);

  // Bus handshake and registered outputs; waitrequest idles high so it comes from a flop.
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_ff          <= 1'b0;
      waitrequest     <= 1'b1;
      readdata        <= 32'h0000_0000;
      irq             <= 1'b0;
      masterTerminate <= 1'b0;
    end else begin
      ack_ff          <= accept;
      waitrequest     <= !accept;
      readdata        <= (accept && req.read) ? rdMux : readdata;
      irq             <= irqNext;
      masterTerminate <= evMAbort || evTAbort;
    end
  end

  // Assertions.
  a_addr_parity_sets: assert property (@(posedge clock) disable iff (srst)
    evAddrPar |=> pciStatus_ff[BIT_DET_PARITY] && pciStatus_ff[BIT_SIG_ERROR])
    else $error("Address parity did not set both bits.");

  a_write_parity_only: assert property (@(posedge clock) disable iff (srst)
    evWritePar && !evAddrPar && !$past(pciStatus_ff[BIT_SIG_ERROR]) && !pciStatus_ff[BIT_SIG_ERROR]
    |=> pciStatus_ff[BIT_DET_PARITY] && !pciStatus_ff[BIT_SIG_ERROR])
    else $error("Write parity set the wrong bits.");

  a_master_abort_flag: assert property (@(posedge clock) disable iff (srst)
    evMAbort |=> pciStatus_ff[BIT_RCV_MABORT] && masterTerminate)
    else $error("Master abort not flagged.");

  a_target_abort_flag: assert property (@(posedge clock) disable iff (srst)
    evTAbort |=> pciStatus_ff[BIT_RCV_TABORT] && masterTerminate)
    else $error("Target abort not flagged.");

  a_master_perr_flag: assert property (@(posedge clock) disable iff (srst)
    evMstPerr |=> pciStatus_ff[BIT_MST_DPERR])
    else $error("Master parity report not flagged.");

  a_hub_timeout_set: assert property (@(posedge clock) disable iff (srst)
    hubExpired |=> linkError_ff[BIT_HUB_TIMEOUT] && txSummary_ff)
    else $error("Hub timeout not flagged.");

  a_hub_not_early: assert property (@(posedge clock) disable iff (srst)
    $rose(hubWaiting) |-> !hubExpired [*8])
    else $error("Hub timeout fired too early.");

  a_hbeat_both_bits: assert property (@(posedge clock) disable iff (srst)
    hbeatExpired |=> linkError_ff[BIT_HBEAT_A] && linkError_ff[BIT_HBEAT_B])
    else $error("Heartbeat timeout not flagged in both bits.");

  a_hbeat_restart: assert property (@(posedge clock) disable iff (srst)
    hostTxPulse |=> !hbeatExpired)
    else $error("Heartbeat fired right after host transmit.");

  a_summary_follows: assert property (@(posedge clock) disable iff (srst)
    txPathErr |=> txSummary_ff)
    else $error("Transmit summary not set.");

  a_sticky_hold: assert property (@(posedge clock) disable iff (srst)
    pciStatus_ff[BIT_RCV_MABORT] && !(wrTake && selPci) |=> pciStatus_ff[BIT_RCV_MABORT])
    else $error("Status bit dropped without a clear.");

  a_irq_follows: assert property (@(posedge clock) disable iff (srst)
    |(linkError_ff & irqMask_ff) |=> irq)
    else $error("Interrupt not raised for unmasked bit.");

  a_irq_pci_bits: assert property (@(posedge clock) disable iff (srst)
    |(pciStatus_ff & irqMask_ff) |=> irq)
    else $error("Interrupt not raised for unmasked bus status bit.");

  a_irq_masked_off: assert property (@(posedge clock) disable iff (srst)
    irqMask_ff == 32'h0000_0000 |=> !irq)
    else $error("Interrupt raised with every source masked.");

  // Register bus checks: exactly one wait cycle, and read data that stands.
  a_wait_one_cycle: assert property (@(posedge clock) disable iff (srst)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("Request waited more than one cycle.");

  a_wait_rearms: assert property (@(posedge clock) disable iff (srst)
    !waitrequest |=> waitrequest)
    else $error("Waitrequest stayed low after a completed access.");

  a_read_data_held: assert property (@(posedge clock) disable iff (srst)
    read && !waitrequest |-> readdata == $past(rdMux))
    else $error("Read data does not match the addressed register.");

  a_unmapped_reads_zero: assert property (@(posedge clock) disable iff (srst)
    read && !waitrequest && !(selPci || selLink || selCtrl || selMask) |-> readdata == 32'h0000_0000)
    else $error("Unmapped address read as nonzero.");

  // Events that must be refused in the wrong bus role leave their bits alone.
  a_master_no_sigerr: assert property (@(posedge clock) disable iff (srst)
    pciEvt.isMaster |=> !$rose(pciStatus_ff[BIT_SIG_ERROR]))
    else $error("Signalled error set while master.");

  a_master_no_detpar: assert property (@(posedge clock) disable iff (srst)
    pciEvt.isMaster |=> !$rose(pciStatus_ff[BIT_DET_PARITY]))
    else $error("Detected parity set while master.");

  a_target_no_mterm: assert property (@(posedge clock) disable iff (srst)
    !pciEvt.isMaster |=> !masterTerminate)
    else $error("Own transaction ended while not master.");

  a_target_no_mperr: assert property (@(posedge clock) disable iff (srst)
    !pciEvt.isMaster |=> !$rose(pciStatus_ff[BIT_MST_DPERR]))
    else $error("Master parity bit set while not master.");

  // Link timers stay quiet when the wait has ended or is disabled; a heartbeat timeout sets the summary.
  a_hub_grant_quiet: assert property (@(posedge clock) disable iff (srst)
    gntSync2_ff |=> !hubExpired)
    else $error("Hub timeout fired after grant.");

  a_hbeat_off_quiet: assert property (@(posedge clock) disable iff (srst)
    !hbeatEnable_ff |=> !hbeatExpired)
    else $error("Heartbeat fired while disabled.");

  a_hbeat_not_early: assert property (@(posedge clock) disable iff (srst)
    hostTxPulse |=> !hbeatExpired [*8])
    else $error("Heartbeat fired too soon after host transmit.");

  a_hbeat_summary: assert property (@(posedge clock) disable iff (srst)
    hbeatExpired |=> txSummary_ff)
    else $error("Heartbeat timeout did not set the summary.");

  // Sticky behaviour: only a write of one clears, and a set beats it.
  a_link_sticky: assert property (@(posedge clock) disable iff (srst)
    linkError_ff[BIT_HUB_TIMEOUT] && !(wrTake && selLink) |=> linkError_ff[BIT_HUB_TIMEOUT])
    else $error("Link error bit dropped without a clear.");

  a_summary_sticky: assert property (@(posedge clock) disable iff (srst)
    txSummary_ff && !clrSum |=> txSummary_ff)
    else $error("Summary bit dropped without a clear.");

  a_clear_works: assert property (@(posedge clock) disable iff (srst)
    wrTake && selPci && wrLanes[BIT_RCV_MABORT] && !evMAbort |=> !pciStatus_ff[BIT_RCV_MABORT])
    else $error("Write of one did not clear the status bit.");

  a_set_beats_clear: assert property (@(posedge clock) disable iff (srst)
    evMAbort && wrTake && selPci |=> pciStatus_ff[BIT_RCV_MABORT])
    else $error("Clear won over a new event.");

endmodule // cluster_adapter_error_status

/* test/hub_model.sv */
// Purpose: Behavioural hub that answers a raised link request with a grant.
// Assumes: The bench sets the latency; a large one leaves the request unanswered.
// Notes:   Grant is driven at all times and drops on the first clock edge after the request goes away.
`timescale 1ns/1ps
module hub_model (
  // Clock.
  input  wire logic clock,
  // Link handshake.
  input  wire logic linkRequest,
  input  var  int   latency,
  output logic      linkGrant
);
  int waitCnt_ff = 0;

  // Count the wait and grant once the chosen latency has passed.
  always @(posedge clock) begin
    if (!linkRequest) begin
      waitCnt_ff <= 0;
      linkGrant <= 1'b0;
    end else if (waitCnt_ff >= latency) begin
      linkGrant <= 1'b1;
    end else begin
      waitCnt_ff <= waitCnt_ff + 1;
    end
  end
endmodule // hub_model

/* test/cluster_adapter_error_status_test.sv */
// Purpose: Self-checking bench for the adapter error status block.
// Assumes: Every bus access ends when waitrequest is seen low.
// Notes:   Timer limits are shortened so the heartbeat fits in a short run.
`timescale 1ns/1ps
module cluster_adapter_error_status_test;
  import cluster_err_pkg::*;
  localparam int HUB_T = 20;
  localparam int HB_T  = 50;
  logic        clock       = 1'b0;
  logic        srst        = 1'b1;
  logic [3:0]  address     = 4'h0;
  logic        read        = 1'b0;
  logic        write       = 1'b0;
  logic [3:0]  byteenable  = 4'hF;
  logic [31:0] writedata   = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  pci_evt_type pciEvt      = '0;
  logic        linkRequest = 1'b0;
  logic        linkGrant;
  logic        hostTxPulse = 1'b0;
  logic        masterTerminate;
  logic        irq;
  int          hubLatency  = 0;
  int          n_fail      = 0;
  int          n_checks    = 0;
  int          cycles      = 0;
  logic [31:0] rd;

  cluster_adapter_error_status #(.HUB_LIMIT(HUB_T), .HBEAT_LIMIT(HB_T)) uut (
    .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pciEvt(pciEvt), .linkRequest(linkRequest),
    .linkGrant(linkGrant), .hostTxPulse(hostTxPulse),
    .masterTerminate(masterTerminate), .irq(irq));

  hub_model hub (.clock(clock), .linkRequest(linkRequest), .latency(hubLatency),
    .linkGrant(linkGrant));

  // Free-running clock.
  always #12.5 clock = ~clock;

  // A hang is cut short well above the expected run of about six hundred cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access; the request stands until waitrequest is seen low.
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask

  task automatic pulse(input pci_evt_type e);
    @(posedge clock);
    pciEvt <= e;
    @(posedge clock);
    pciEvt <= '0;
    @(negedge clock);
  endtask

  task automatic reset_values();
    check({31'h0, irq}, 32'h0);
    rdchk(OFS_PCI_STATUS, RST_STATUS);
    rdchk(OFS_LINK_ERROR, RST_STATUS);
    rdchk(OFS_LINK_CTRL, 32'h0001_0000);
    rdchk(OFS_IRQ_MASK, RST_MASK);
    bus(4'h2, 1'b1, 32'hFFFF_FFFF);
    rdchk(4'h2, 32'h0);
    bus(OFS_LINK_CTRL, 1'b1, 32'h0);
    bus(OFS_LINK_ERROR, 1'b1, 32'hFFFF_FFFF);
    rdchk(OFS_LINK_CTRL, 32'h0);
  endtask

  // Each event, including the two that must be refused, then a full clear.
  task automatic pci_errors();
    logic [5:0]  ev [7];
    logic [31:0] st [7];
    logic [1:0]  sm [7];
    ev = '{6'h20, 6'h08, 6'h14, 6'h12, 6'h11, 6'h30, 6'h04};
    st = '{32'hC0000000, 32'h80000000, 32'h20000000, 32'h10000000, 32'h01000000,
           32'h00000000, 32'h00000000};
    sm = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h0, 2'h0};
    for (int i = 0; i < 7; i++) begin
      pulse(pci_evt_type'(ev[i]));
      check({31'h0, masterTerminate}, {31'h0, sm[i][0]});
      repeat (4) @(posedge clock);
      rdchk(OFS_PCI_STATUS, st[i]);
      rdchk(OFS_LINK_CTRL, {31'h0, sm[i][1]});
      bus(OFS_PCI_STATUS, 1'b1, 32'hFFFF_FFFF);
      bus(OFS_LINK_CTRL, 1'b1, 32'h0000_0001);
      rdchk(OFS_PCI_STATUS, 32'h0);
    end
  endtask

  // A clear that lands on the same edge as a new event loses to it.
  task automatic set_wins();
    @(posedge clock);
    address <= OFS_PCI_STATUS;
    write <= 1'b1;
    writedata <= 32'hFFFF_FFFF;
    @(posedge clock);
    pciEvt <= pci_evt_type'(6'h14);
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
    pciEvt <= '0;
    rdchk(OFS_PCI_STATUS, 32'h2000_0000);
    bus(OFS_PCI_STATUS, 1'b1, 32'hFFFF_FFFF);
    bus(OFS_LINK_CTRL, 1'b1, 32'h0000_0001);
  endtask

  // Masking holds the interrupt back; clearing one bit leaves the other set.
  task automatic irq_path();
    pulse(pci_evt_type'(6'h20));
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h0);
    bus(OFS_IRQ_MASK, 1'b1, 32'h8000_0000);
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h1);
    bus(OFS_PCI_STATUS, 1'b1, 32'h8000_0000);
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h0);
    rdchk(OFS_PCI_STATUS, 32'h4000_0000);
    bus(OFS_PCI_STATUS, 1'b1, 32'hFFFF_FFFF);
    bus(OFS_IRQ_MASK, 1'b1, 32'h0);
  endtask

  task automatic link_wait(input int lat, input logic [31:0] exp);
    hubLatency = lat;
    @(posedge clock);
    linkRequest <= 1'b1;
    repeat (HUB_T + 20) @(posedge clock);
    linkRequest <= 1'b0;
    repeat (4) @(posedge clock);
    rdchk(OFS_LINK_ERROR, exp);
    rdchk(OFS_LINK_CTRL, {31'h0, exp[BIT_HUB_TIMEOUT]});
    bus(OFS_LINK_ERROR, 1'b1, 32'hFFFF_FFFF);
    bus(OFS_LINK_CTRL, 1'b1, 32'h0000_0001);
  endtask

  // Host traffic inside the period keeps the timer quiet; silence trips it.
  task automatic heartbeat();
    bus(OFS_LINK_CTRL, 1'b1, 32'h0001_0000);
    repeat (5) begin
      repeat (HB_T - 20) @(posedge clock);
      hostTxPulse <= 1'b1;
      @(posedge clock);
      hostTxPulse <= 1'b0;
    end
    rdchk(OFS_LINK_ERROR, 32'h0);
    repeat (HB_T + 10) @(posedge clock);
    rdchk(OFS_LINK_ERROR, 32'h2800_0000);
    rdchk(OFS_LINK_CTRL, 32'h0001_0001);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    reset_values();
    pci_errors();
    set_wins();
    irq_path();
    link_wait(3, 32'h0);
    link_wait(500, 32'h4000_0000);
    heartbeat();
    conclude();
  end
endmodule // cluster_adapter_error_status_test
